// [hdl/fdcd_pkg.sv]
// Package of constants for the fieldbus drive command decoder
`default_nettype none
package fdcd_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_SETPOINT  = 8'h08;
  localparam logic [7:0] ADDR_RAMP      = 8'h0C;
  localparam logic [7:0] ADDR_SLAVE     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h1C;
  localparam logic [7:0] ADDR_PARAM     = 8'h20;
  // ==========================================================
  // Control register fields
  localparam int CTRL_OPT_LSB    = 0;
  localparam int CTRL_PROG_EN    = 4;
  localparam int CTRL_FAULT_SET  = 5;
  localparam logic [3:0] OPT_BASIC      = 4'h0;
  localparam logic [3:0] OPT_RAPID      = 4'h7;
  localparam logic [3:0] OPT_ZERO_MIN   = 4'h8;
  localparam logic [3:0] OPT_LOW_TORQUE = 4'hA;
  localparam logic [3:0] OPT_NO_PHASE   = 4'hB;
  localparam logic [3:0] OPT_NO_SLIP    = 4'hE;
  // ==========================================================
  // Slave addressing
  localparam logic [4:0] SLAVE_ADDR_RESET = 5'h00;
  localparam logic [4:0] SLAVE_ADDR_MAX   = 5'h1F;
  // Profile code value is arbitrary
  localparam logic [7:0] PROFILE_CODE     = 8'h5A;
  // ==========================================================
  // Interrupt bits
  localparam int IRQ_FAULT  = 0;
  localparam int IRQ_RESET  = 1;
  localparam int IRQ_ADDR   = 2;
  localparam int IRQ_WIDTH  = 3;
  // ==========================================================
  // Setpoint units: 0.1 Hz, ramp units: 0.1 s
  localparam logic [3:0] SWITCH_MAX      = 4'hA;
  localparam logic [9:0] RAMP_STEP_HZ    = 10'h1F4;
  localparam logic [31:0] AXI_OKAY       = 32'h0;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0] {
    FDCD_DIR_STOP = 2'h0,
    FDCD_DIR_CW   = 2'h1,
    FDCD_DIR_CCW  = 2'h2
  } fdcd_dir_t;
endpackage : fdcd_pkg
`default_nettype wire

// [hdl/fdcd_top.sv]
// Command, setpoint and option decoding for a fieldbus motor drive
`default_nettype none
module fdcd_top (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  master_out_bits_in,
  output logic      [3:0]  master_in_bits_out,
  input  wire logic [9:0]  potentiometer_speed_setpoint_in,
  input  wire logic [3:0]  second_speed_switch_in,
  input  wire logic [3:0]  ramp_time_switch_in,
  input  wire logic        supply_select_switch_in,
  input  wire logic        sensor_input_a_in,
  input  wire logic        sensor_input_b_in,
  input  wire logic        phase_loss_in,
  input  wire logic        drive_fault_in,
  input  wire logic        addr_assign_in,
  input  wire logic [4:0]  addr_assign_value_in,
  output logic [1:0]       direction_out,
  output logic             drive_enable_out,
  output logic [9:0]       speed_setpoint_out,
  output logic [6:0]       ramp_time_out,
  output logic             premag_enable_out,
  output logic             slip_comp_enable_out,
  output logic             reduced_torque_out,
  output logic             phase_monitor_enable_out,
  output logic             aux_supply_select_out,
  output logic             fault_out,
  output logic [4:0]       slave_addr_out,
  output logic             irq_out,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================
  // Decode tables
  function automatic logic [9:0] fdcd_speed(input logic [3:0] pos,
                                            input logic zero_min);
    unique case (pos)
      4'h0: fdcd_speed = zero_min ? 10'h000 : 10'h032;
      4'h1: fdcd_speed = 10'h046;
      4'h2: fdcd_speed = 10'h064;
      4'h3: fdcd_speed = 10'h096;
      4'h4: fdcd_speed = 10'h0C8;
      4'h5: fdcd_speed = 10'h0FA;
      4'h6: fdcd_speed = 10'h15E;
      4'h7: fdcd_speed = 10'h1F4;
      4'h8: fdcd_speed = 10'h258;
      4'h9: fdcd_speed = 10'h2BC;
      default: fdcd_speed = 10'h3E8;
    endcase
  endfunction : fdcd_speed

  function automatic logic [6:0] fdcd_ramp(input logic [3:0] pos);
    unique case (pos)
      4'h0: fdcd_ramp = 7'h01;
      4'h1: fdcd_ramp = 7'h02;
      4'h2: fdcd_ramp = 7'h03;
      4'h3: fdcd_ramp = 7'h05;
      4'h4: fdcd_ramp = 7'h07;
      4'h5: fdcd_ramp = 7'h0A;
      4'h6: fdcd_ramp = 7'h14;
      4'h7: fdcd_ramp = 7'h1E;
      4'h8: fdcd_ramp = 7'h32;
      4'h9: fdcd_ramp = 7'h46;
      default: fdcd_ramp = 7'h64;
    endcase
  endfunction : fdcd_ramp

  // ==========================================================
  // State
  localparam int IRQ_WIDTH_L = fdcd_pkg::IRQ_WIDTH;

  typedef struct packed {
    logic [3:0]  option;
    logic        prog_en;
    logic [3:0]  prog_data;
    logic [3:0]  param_bits;
    logic [4:0]  slave_addr;
    logic        bit3_prev;
    logic        fault;
    logic [IRQ_WIDTH_L-1:0] irq_stat;
    logic [IRQ_WIDTH_L-1:0] irq_en;
    logic [1:0]  dir;
    logic        enable;
    logic [9:0]  speed;
    logic [6:0]  ramp;
    logic        premag;
    logic        slip;
    logic        torque;
    logic        phase_mon;
    logic        aux;
    logic [3:0]  in_bits;
    logic        irq;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fdcd_state_t;

  fdcd_state_t st_ff;
  fdcd_state_t nxt_st;

  always_comb
  begin
    logic [3:0]  cmd;
    logic [2:0]  ev;
    logic        zero_min;
    logic        do_wr;
    logic [31:0] wd;
    cmd = 4'h0;
    ev = 3'h0;
    zero_min = 1'b0;
    do_wr = 1'b0;
    wd = 32'h0;
    nxt_st = st_ff;
    // Programmer overrides the master's data bits while connected
    cmd = st_ff.prog_en ? st_ff.prog_data : master_out_bits_in;
    // ========================================================
    // Command decode
    unique case (cmd[1:0])
      2'b01: nxt_st.dir = fdcd_pkg::FDCD_DIR_CW;
      2'b10: nxt_st.dir = fdcd_pkg::FDCD_DIR_CCW;
      default: nxt_st.dir = fdcd_pkg::FDCD_DIR_STOP;
    endcase
    nxt_st.bit3_prev = cmd[3];
    if (cmd[3] && !st_ff.bit3_prev && st_ff.fault)
    begin
      nxt_st.fault = 1'b0;
      ev[fdcd_pkg::IRQ_RESET] = 1'b1;
    end
    if (drive_fault_in ||
        (phase_loss_in && st_ff.option != fdcd_pkg::OPT_NO_PHASE))
    begin
      nxt_st.fault = 1'b1;
      ev[fdcd_pkg::IRQ_FAULT] = 1'b1;
    end
    nxt_st.enable = cmd[3] && !st_ff.fault;
    // ========================================================
    // Setpoint and options
    zero_min = st_ff.option == fdcd_pkg::OPT_ZERO_MIN ||
               st_ff.option == fdcd_pkg::OPT_LOW_TORQUE;
    nxt_st.speed = cmd[2] ? fdcd_speed(second_speed_switch_in, zero_min)
                          : potentiometer_speed_setpoint_in;
    nxt_st.ramp = fdcd_ramp(ramp_time_switch_in);
    nxt_st.premag = st_ff.option != fdcd_pkg::OPT_RAPID;
    nxt_st.slip = st_ff.option != fdcd_pkg::OPT_NO_SLIP;
    nxt_st.torque = st_ff.option == fdcd_pkg::OPT_LOW_TORQUE;
    nxt_st.phase_mon = st_ff.option != fdcd_pkg::OPT_NO_PHASE;
    nxt_st.aux = supply_select_switch_in;
    // Ready follows the fault flag in the same cycle
    nxt_st.in_bits = {sensor_input_b_in, sensor_input_a_in,
                      1'b0, !nxt_st.fault};
    // ========================================================
    // Master address assignment, only onto address 0
    if (addr_assign_in && st_ff.slave_addr == fdcd_pkg::SLAVE_ADDR_RESET &&
        addr_assign_value_in != fdcd_pkg::SLAVE_ADDR_RESET)
    begin
      nxt_st.slave_addr = addr_assign_value_in;
      ev[fdcd_pkg::IRQ_ADDR] = 1'b1;
    end
    // ========================================================
    // AXI4-Lite write
    if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    do_wr = st_ff.aw_got && st_ff.w_got;
    wd = st_ff.w_data;
    if (do_wr)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = fdcd_pkg::RESP_OKAY;
      unique case (st_ff.aw_addr)
        fdcd_pkg::ADDR_CTRL:
          if (st_ff.w_strb[0])
          begin
            nxt_st.option = wd[fdcd_pkg::CTRL_OPT_LSB +: 4];
            nxt_st.prog_en = wd[fdcd_pkg::CTRL_PROG_EN];
          end
        fdcd_pkg::ADDR_SLAVE:
          if (st_ff.w_strb[0] && wd[4:0] != fdcd_pkg::SLAVE_ADDR_RESET)
            nxt_st.slave_addr = wd[4:0];
        fdcd_pkg::ADDR_PARAM:
          if (st_ff.w_strb[0])
          begin
            nxt_st.prog_data = wd[3:0];
            nxt_st.param_bits = wd[7:4];
          end
        fdcd_pkg::ADDR_IRQ_EN:
          if (st_ff.w_strb[0])
            nxt_st.irq_en = wd[IRQ_WIDTH_L-1:0];
        fdcd_pkg::ADDR_IRQ_CLR:
          if (st_ff.w_strb[0])
            nxt_st.irq_stat = st_ff.irq_stat & ~wd[IRQ_WIDTH_L-1:0];
        fdcd_pkg::ADDR_STATUS, fdcd_pkg::ADDR_SETPOINT,
        fdcd_pkg::ADDR_RAMP, fdcd_pkg::ADDR_IRQ_STAT: ;
        default: nxt_st.bresp = fdcd_pkg::RESP_SLVERR;
      endcase
    end
    // Set wins over clear
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
    nxt_st.irq = |(st_ff.irq_stat & st_ff.irq_en);
    // ========================================================
    // AXI4-Lite read
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
    if (s_axi_arvalid && !st_ff.rvalid)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = fdcd_pkg::RESP_OKAY;
      nxt_st.rdata = 32'h0;
      unique case (s_axi_araddr)
        fdcd_pkg::ADDR_CTRL:
          nxt_st.rdata = {26'h0, st_ff.fault, st_ff.prog_en, st_ff.option};
        fdcd_pkg::ADDR_STATUS:
          nxt_st.rdata = {20'h0, st_ff.aux, st_ff.enable, st_ff.dir,
                          st_ff.in_bits, cmd};
        fdcd_pkg::ADDR_SETPOINT: nxt_st.rdata = {22'h0, st_ff.speed};
        fdcd_pkg::ADDR_RAMP:     nxt_st.rdata = {25'h0, st_ff.ramp};
        fdcd_pkg::ADDR_SLAVE:
          nxt_st.rdata = {16'h0, fdcd_pkg::PROFILE_CODE,
                          3'h0, st_ff.slave_addr};
        fdcd_pkg::ADDR_IRQ_STAT:
          nxt_st.rdata = {29'h0, st_ff.irq_stat};
        fdcd_pkg::ADDR_IRQ_EN:
          nxt_st.rdata = {29'h0, st_ff.irq_en};
        fdcd_pkg::ADDR_PARAM:
          nxt_st.rdata = {24'h0, st_ff.param_bits, st_ff.prog_data};
        fdcd_pkg::ADDR_IRQ_CLR: ;
        default: nxt_st.rresp = fdcd_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_ff <= '0;
      st_ff.slave_addr <= fdcd_pkg::SLAVE_ADDR_RESET;
      st_ff.premag <= 1'b1;
      st_ff.slip <= 1'b1;
      st_ff.phase_mon <= 1'b1;
      // Ready from reset, as no fault is held
      st_ff.in_bits <= 4'h1;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Outputs straight from the state register, except the AXI readies, which are decoded from its bits
  assign master_in_bits_out       = st_ff.in_bits;
  assign direction_out            = st_ff.dir;
  assign drive_enable_out         = st_ff.enable;
  assign speed_setpoint_out       = st_ff.speed;
  assign ramp_time_out            = st_ff.ramp;
  assign premag_enable_out        = st_ff.premag;
  assign slip_comp_enable_out     = st_ff.slip;
  assign reduced_torque_out       = st_ff.torque;
  assign phase_monitor_enable_out = st_ff.phase_mon;
  assign aux_supply_select_out    = st_ff.aux;
  assign fault_out                = st_ff.fault;
  assign slave_addr_out           = st_ff.slave_addr;
  assign irq_out                  = st_ff.irq;
  assign s_axi_awready            = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready             = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bresp              = st_ff.bresp;
  assign s_axi_bvalid             = st_ff.bvalid;
  assign s_axi_arready            = !st_ff.rvalid;
  assign s_axi_rdata              = st_ff.rdata;
  assign s_axi_rresp              = st_ff.rresp;
  assign s_axi_rvalid             = st_ff.rvalid;
endmodule : fdcd_top
`default_nettype wire

// [verif/fdcd_asserts.sv]
// Port assertions for the drive command decoder
`default_nettype none
module fdcd_chk (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [3:0] master_out_bits_in,
  input wire logic [3:0] master_in_bits_out,
  input wire logic       sensor_input_a_in,
  input wire logic       sensor_input_b_in,
  input wire logic       drive_fault_in,
  input wire logic [1:0] direction_out,
  input wire logic       drive_enable_out,
  input wire logic       fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Fault reset steps
  sequence s_rise;
    fault_out && !drive_fault_in && $rose(master_out_bits_in[3]);
  endsequence
  sequence s_held;
    master_out_bits_in[3] && !drive_fault_in;
  endsequence
  // ==========================================================
  // Checks
  a_bit1_zero: assert property (master_in_bits_out[1] == 1'b0)
    else $error("returned bit1 set");
  a_ready_fault: assert property (master_in_bits_out[0] != fault_out)
    else $error("ready does not track fault");
  a_sensor_echo: assert property (1'b1 |=>
    master_in_bits_out[3:2] == $past({sensor_input_b_in, sensor_input_a_in}))
    else $error("sensor bits wrong");
  a_dir_decode: assert property (1'b1 |=> direction_out ==
    $past({master_out_bits_in[1] & ~master_out_bits_in[0],
           master_out_bits_in[0] & ~master_out_bits_in[1]}))
    else $error("direction wrong");
  a_enable_gate: assert property (!master_out_bits_in[3] |=>
    !drive_enable_out)
    else $error("enabled without bit3");
  a_fault_hold: assert property (fault_out &&
    !master_out_bits_in[3] |=> fault_out)
    else $error("fault dropped without reset edge");
  a_fault_clear: assert property (s_rise |=> !fault_out)
    else $error("fault not cleared by reset edge");
  a_enable_after: assert property (s_rise ##1 s_held |=>
    drive_enable_out)
    else $error("enable missing after reset");
endmodule : fdcd_chk
bind fdcd_top fdcd_chk u_chk (.*);
`default_nettype wire

// [verif/fdcd_master_model.sv]
// Behavioural fieldbus master feeding the decoder
`default_nettype none
module fdcd_master_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] cmd_in,
  input  wire logic       assign_req_in,
  input  wire logic       rogue_in,
  input  wire logic [4:0] assign_val_in,
  input  wire logic [4:0] slave_addr_in,
  output logic      [3:0] bits_out,
  output logic            assign_out,
  output logic      [4:0] assign_value_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rogue lets a scenario assign to an already addressed slave
  always_ff @(posedge clk_in)
  begin
    bits_out <= cmd_in;
    assign_out <= assign_req_in && (slave_addr_in == 5'h00 || rogue_in);
    assign_value_out <= assign_val_in;
  end
endmodule : fdcd_master_model
`default_nettype wire

// [verif/fdcd_top_test.sv]
// Self-checking bench for the drive command decoder
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module fdcd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [31:0] exp; int sel;} fdcd_note_t;
  logic clk_in, rst_in, supply_select_switch_in, sensor_input_a_in;
  logic sensor_input_b_in, phase_loss_in, drive_fault_in, addr_assign_in;
  logic premag_enable_out, slip_comp_enable_out, reduced_torque_out;
  logic phase_monitor_enable_out, aux_supply_select_out, fault_out, irq_out;
  logic drive_enable_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, req, rogue;
  logic [1:0]  s_axi_bresp, s_axi_rresp, direction_out, rd_resp;
  logic [3:0]  master_out_bits_in, master_in_bits_out, s_axi_wstrb, cmd, o;
  logic [3:0]  second_speed_switch_in, ramp_time_switch_in;
  logic [4:0]  addr_assign_value_in, slave_addr_out, aval;
  logic [6:0]  ramp_time_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [9:0]  potentiometer_speed_setpoint_in, speed_setpoint_out;
  logic [15:0] r;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, e;
  int          n_mismatch, checks, f2_tab[11], t1_tab[11];
  logic [3:0]  opts[6];
  fdcd_note_t  notes[$], cur;

  fdcd_top u_dut (.*);
  fdcd_master_model u_master (.clk_in(clk_in), .cmd_in(cmd),
    .assign_req_in(req), .rogue_in(rogue), .assign_val_in(aval),
    .slave_addr_in(slave_addr_out), .bits_out(master_out_bits_in),
    .assign_out(addr_assign_in), .assign_value_out(addr_assign_value_in));

  always #2.5 clk_in = ~clk_in;
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] seen(input int sel);
    case (sel)
      0: return 32'(speed_setpoint_out);
      1: return 32'(ramp_time_out);
      2: return {28'h0, premag_enable_out, slip_comp_enable_out,
                 reduced_torque_out, phase_monitor_enable_out};
      3: return {29'h0, drive_enable_out, direction_out};
      4: return 32'(master_in_bits_out);
      5: return {30'h0, fault_out, irq_out};
      6: return 32'(slave_addr_out);
      7: return rd_val;
      8: return 32'(rd_resp);
      default: return 32'(aux_supply_select_out);
    endcase
  endfunction : seen
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic hang();
    n_mismatch++;
    summarize();
  endtask : hang
  task automatic note(input string nm, input logic [31:0] x, input int sel);
    repeat (3) @(posedge clk_in);
    notes.push_back(fdcd_note_t'{nm, x, sel});
  endtask : note
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
    rd_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200)
      hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200)
      hang();
  endtask : rd
  // Compares each queued note against the settled outputs
  always @(negedge clk_in)
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      `CHK(cur.nm, cur.exp, seen(cur.sel))
    end
  // ==========================================================
  // Main sequence
  initial
  begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {cmd, req, rogue, aval, supply_select_switch_in} = '0;
    {sensor_input_a_in, sensor_input_b_in, phase_loss_in} = '0;
    {drive_fault_in, second_speed_switch_in, ramp_time_switch_in} = '0;
    {potentiometer_speed_setpoint_in, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wdata} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    n_mismatch = 0;
    checks = 0;
    r = 16'h002C;
    f2_tab = '{50, 70, 100, 150, 200, 250, 350, 500, 600, 700, 1000};
    t1_tab = '{1, 2, 3, 5, 7, 10, 20, 30, 50, 70, 100};
    opts = '{4'h0, 4'h7, 4'h8, 4'hA, 4'hB, 4'hE};
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(fdcd_pkg::ADDR_SLAVE);
    note("slave", {16'h0, fdcd_pkg::PROFILE_CODE, 8'h00}, 7);
    rd(8'h40);
    note("unmapped", 32'(fdcd_pkg::RESP_SLVERR), 8);
    wr(8'h40, 32'h0);
    note("wresp", 32'(fdcd_pkg::RESP_SLVERR), 8);
    cmd <= 4'h4;
    foreach (opts[i])
    begin
      o = opts[i];
      wr(fdcd_pkg::ADDR_CTRL, 32'(o));
      note("opts", {28'h0, o != 4'h7, o != 4'hE, o == 4'hA, o != 4'hB}, 2);
      for (int p = 0; p <= 10; p++)
      begin
        second_speed_switch_in <= 4'(p);
        ramp_time_switch_in <= 4'(p);
        e = (p == 0 && (o == 4'h8 || o == 4'hA)) ? 32'h0 : 32'(f2_tab[p]);
        note("speed", e, 0);
        note("ramp", 32'(t1_tab[p]), 1);
      end
      phase_loss_in <= (o == 4'hB);
      note("fault", 32'h0, 5);
      phase_loss_in <= 1'b0;
    end
    cmd <= 4'h0;
    repeat (4)
    begin
      r = lfsr(r);
      potentiometer_speed_setpoint_in <= r[9:0];
      second_speed_switch_in <= r[13:10];
      {sensor_input_b_in, sensor_input_a_in} <= r[15:14];
      supply_select_switch_in <= r[0];
      note("speed", 32'(r[9:0]), 0);
      note("inbits", {28'h0, r[15:14], 2'b01}, 4);
      note("aux", 32'(r[0]), 9);
    end
    for (int d = 0; d < 4; d++)
    begin
      cmd <= {2'b10, 2'(d)};
      note("dir", {29'h1, d == 2, d == 1}, 3);
    end
    cmd <= 4'h3;
    note("dir", 32'h0, 3);
    wr(fdcd_pkg::ADDR_IRQ_EN, 32'h0);
    drive_fault_in <= 1'b1;
    note("fault", 32'h2, 5);
    drive_fault_in <= 1'b0;
    note("fault", 32'h2, 5);
    cmd <= 4'hB;
    note("fault", 32'h0, 5);
    note("dir", 32'h4, 3);
    rd(fdcd_pkg::ADDR_IRQ_STAT);
    note("irqstat", 32'h3, 7);
    wr(fdcd_pkg::ADDR_IRQ_EN, 32'h7);
    note("irq", 32'h1, 5);
    wr(fdcd_pkg::ADDR_IRQ_CLR, 32'h7);
    note("irq", 32'h0, 5);
    cmd <= 4'h3;
    note("dir", 32'h0, 3);
    cmd <= 4'hB;
    note("dir", 32'h4, 3);
    rd(fdcd_pkg::ADDR_IRQ_STAT);
    note("irqstat", 32'h0, 7);
    aval <= 5'h05;
    req <= 1'b1;
    note("addr", 32'h5, 6);
    {rogue, aval} <= {1'b1, 5'h09};
    note("addr", 32'h5, 6);
    req <= 1'b0;
    rd(fdcd_pkg::ADDR_IRQ_STAT);
    note("irqstat", 32'h4, 7);
    note("irq", 32'h1, 5);
    wr(fdcd_pkg::ADDR_SLAVE, 32'h1F);
    note("wresp", 32'(fdcd_pkg::RESP_OKAY), 8);
    note("addr", 32'h1F, 6);
    wr(fdcd_pkg::ADDR_SLAVE, 32'h0);
    note("addr", 32'h1F, 6);
    wr(fdcd_pkg::ADDR_PARAM, 32'hA5);
    rd(fdcd_pkg::ADDR_PARAM);
    note("param", 32'hA5, 7);
    repeat (4) @(posedge clk_in);
    summarize();
  end
endmodule : fdcd_top_test
`default_nettype wire
